// *** common/spdee_pkg.sv ***
/*
 * Shared constants, types and helpers of the presence-detect memory two-wire target.
 * Assumes a 20 MHz core clock and a bus master that runs the serial clock.
 */
package spdee_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam longint CLK_PERIOD_NS  = 64'h0000_0000_0000_0032;
	localparam longint TIMEOUT_MIN_NS = 64'h0000_0000_017D_7840;
	localparam longint TIMEOUT_MAX_NS = 64'h0000_0000_0216_0EC0;
	localparam int     TIMEOUT_CYC    = int'((TIMEOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int     TIMEOUT_MAXCYC = int'(TIMEOUT_MAX_NS / CLK_PERIOD_NS);
	localparam int     WRITE_CYC      = 32'h0000_00C8;

	////////////////////////////////////////////////////////////////////////////////
	// Storage and transfer sizes.
	localparam int         MEM_WORDS      = 32'h0000_0200;
	localparam int         MEM_AW         = 32'h0000_0009;
	localparam int         FIFO_W         = 32'h0000_0011;
	localparam int         FIFO_DEPTH     = 32'h0000_0020;
	localparam logic [7:0] ERASED         = 8'hFF;
	localparam logic [4:0] PAGE_BYTES_MAX = 5'h10;
	localparam logic [3:0] BYTE_BITS      = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions of the select byte and of the pin vector.
	localparam int DS_ID_HI  = 7;
	localparam int DS_ID_LO  = 4;
	localparam int DS_SEL_HI = 3;
	localparam int DS_SEL_LO = 1;
	localparam int DS_RW     = 0;
	localparam int PIN_SCL   = 0;
	localparam int PIN_SDA   = 1;
	localparam int PIN_S_LO  = 2;
	localparam int PIN_S_HI  = 4;
	localparam int PIN_HV    = 5;
	localparam int PIN_N     = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Protection and page command codes in the select field.
	localparam logic [2:0] CMD_BLK0 = 3'h1;
	localparam logic [2:0] CMD_BLK1 = 3'h4;
	localparam logic [2:0] CMD_BLK2 = 3'h5;
	localparam logic [2:0] CMD_BLK3 = 3'h0;
	localparam logic [2:0] CMD_CLR  = 3'h3;
	localparam logic [2:0] CMD_PG0  = 3'h6;
	localparam logic [2:0] CMD_PG1  = 3'h7;

	typedef enum logic [2:0] {
		S_IDLE, S_DEV, S_WADDR, S_WDATA, S_PDUMMY, S_RDATA, S_WCYC
	} spdee_state_t;

	// Maps a set_block_protect_cmd code to its block number.
	function automatic logic [1:0] spdee_blk(input logic [2:0] c);
		unique case (c)
			CMD_BLK0: spdee_blk = 2'h0;
			CMD_BLK1: spdee_blk = 2'h1;
			CMD_BLK2: spdee_blk = 2'h2;
			default:  spdee_blk = 2'h3;
		endcase
	endfunction

	// True for the four block codes.
	function automatic logic spdee_is_blk(input logic [2:0] c);
		spdee_is_blk = (c == CMD_BLK0) || (c == CMD_BLK1) || (c == CMD_BLK2) || (c == CMD_BLK3);
	endfunction

endpackage

// *** common/spdee_stream_if.sv ***
/*
 * Valid and ready word stream between the target core and its write buffer.
 * Assumes both ends share one clock and reset.
 */
`timescale 1ns/1ns
interface spdee_stream_if #(parameter int W = 17) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

// *** logic/spdee_fifo.sv ***
/*
 * Write-data FIFO in flip-flops, width and depth set by parameters.
 * Assumes an asynchronous active-low reset copy, released on a clock edge, from the target top.
 */
`timescale 1ns/1ns
module spdee_fifo #(
	parameter int W     = 17,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input wire logic          clk,
	input wire logic          rst_n,
	// Streams.
	spdee_stream_if.sink      in_if,
	spdee_stream_if.source    out_if
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || W < 1) begin : g_bad
		$error("FIFO depth below two or width below one.");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wptr;
		logic [AW-1:0]           rptr;
		logic [AW:0]             count;
	} spdee_fifo_t;

	spdee_fifo_t q;
	spdee_fifo_t next_q;
	logic        push;
	logic        pop;

	assign in_if.ready  = (q.count != (AW+1)'(DEPTH));
	assign out_if.valid = (q.count != '0);
	assign out_if.data  = q.mem[q.rptr];
	assign push         = in_if.valid && in_if.ready;
	assign pop          = out_if.valid && out_if.ready;

	always_comb begin
		next_q = q;
		if (push) begin
			next_q.mem[q.wptr] = in_if.data;
			next_q.wptr = (q.wptr == AW'(DEPTH-1)) ? '0 : q.wptr + 1'b1;
		end
		if (pop) begin
			next_q.rptr = (q.rptr == AW'(DEPTH-1)) ? '0 : q.rptr + 1'b1;
		end
		if (push && !pop) begin
			next_q.count = q.count + 1'b1;
		end else if (pop && !push) begin
			next_q.count = q.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	a_fifo_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
		q.count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
	a_fifo_push_count: assert property (@(posedge clk) disable iff (!rst_n)
		(push && !pop) |=> q.count == $past(q.count) + 1'b1) else $error("FIFO push lost.");
endmodule

// *** logic/spdee_target.sv ***
/*
 * Two-wire target of a 4 Kbit presence-detect memory: select decode, acknowledge,
 * protection and page commands, clock-low timeout and internal write cycle.
 * Assumes an external pull-up on the data line and a master that owns the clock.
 */
`timescale 1ns/1ns
module spdee_target
	import spdee_pkg::*;
#(
	parameter int         P_TIMEOUT_CYC  = TIMEOUT_CYC,
	parameter int         P_WRITE_CYC    = WRITE_CYC,
	parameter int         P_FIFO_DEPTH   = FIFO_DEPTH,
	// Arbitrary identifier values.
	parameter logic [3:0] P_MEM_TYPE_ID  = 4'h5,
	parameter logic [3:0] P_PROT_TYPE_ID = 4'h3
) (
	// Clock and reset.
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	// Two-wire bus.
	input  wire logic i_scl,
	input  wire logic i_sda,
	output wire logic o_sda_out,
	output wire logic o_sda_oe,
	// Straps.
	input  wire logic i_strap_pin_zero,
	input  wire logic i_strap_pin_one,
	input  wire logic i_strap_pin_two,
	input  wire logic i_high_voltage_sense_level,
	// Status.
	output wire logic o_write_busy
);
	localparam int TW = $clog2(P_TIMEOUT_CYC + 1);
	localparam int WW = $clog2(P_WRITE_CYC + 1);

	if (P_TIMEOUT_CYC < 2 || P_TIMEOUT_CYC > TIMEOUT_MAXCYC || P_WRITE_CYC < 1
		|| P_FIFO_DEPTH < int'(PAGE_BYTES_MAX) || P_MEM_TYPE_ID == P_PROT_TYPE_ID) begin : g_bad
		$error("Target parameters out of range.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		logic [PIN_N-1:0]               sync1;
		logic [PIN_N-1:0]               sync2;
		logic                           scl_d;
		logic                           sda_d;
		spdee_state_t                   st;
		logic [3:0]                     bitcnt;
		logic                           in_ack;
		logic [7:0]                     shreg;
		logic                           prot_rd;
		logic [2:0]                     cmd;
		logic                           pend;
		logic                           page;
		logic [7:0]                     addr;
		logic [3:0]                     wp;
		logic [4:0]                     nbytes;
		logic                           drive_low;
		logic                           push;
		logic [FIFO_W-1:0]              push_data;
		logic [TW-1:0]                  tcnt;
		logic [WW-1:0]                  wcnt;
		logic [MEM_WORDS-1:0][7:0]      mem;
	} spdee_core_t;

	spdee_core_t      q;
	spdee_core_t      next_q;
	logic [1:0]       rst_pipe;
	logic             rst_n;
	logic             scl_h;
	logic             sda_h;
	logic             rise_w;
	logic             fall_w;
	logic             start_w;
	logic             stop_w;
	logic             to_w;
	logic             dec_w;
	logic [2:0]       straps;
	logic [PIN_N-1:0] pins;

	spdee_stream_if #(.W(FIFO_W)) wr_bus ();
	spdee_stream_if #(.W(FIFO_W)) rd_bus ();

	spdee_fifo #(.W(FIFO_W), .DEPTH(P_FIFO_DEPTH)) u_fifo (
		.clk    (i_core_clk),
		.rst_n  (rst_n),
		.in_if  (wr_bus.sink),
		.out_if (rd_bus.source)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reset release.
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'h1};
		end
	end
	assign rst_n = rst_pipe[1];

	////////////////////////////////////////////////////////////////////////////////
	// Bus events.
	// Straps sampled as levels.
	assign pins    = {i_high_voltage_sense_level, i_strap_pin_two, i_strap_pin_one,
		i_strap_pin_zero, i_sda, i_scl};
	assign scl_h   = q.sync2[PIN_SCL];
	assign sda_h   = q.sync2[PIN_SDA];
	assign straps  = q.sync2[PIN_S_HI:PIN_S_LO];
	assign rise_w  = scl_h && !q.scl_d;
	assign fall_w  = !scl_h && q.scl_d;
	assign start_w = scl_h && q.scl_d && q.sda_d && !sda_h;
	assign stop_w  = scl_h && q.scl_d && !q.sda_d && sda_h;
	assign to_w    = !scl_h && (q.tcnt == TW'(P_TIMEOUT_CYC - 1)) && (q.st != S_WCYC);
	assign dec_w   = fall_w && !to_w && (q.st != S_IDLE) && (q.st != S_WCYC)
		&& (q.bitcnt == BYTE_BITS) && !q.in_ack;

	assign wr_bus.valid = q.push;
	assign wr_bus.data  = q.push_data;
	assign rd_bus.ready = (q.st == S_WCYC);
	// Data line only pulled low; no clock output exists.
	assign o_sda_out    = 1'h0;
	assign o_sda_oe     = q.drive_low;
	assign o_write_busy = (q.st == S_WCYC);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		next_q = q;
		next_q.sync1 = pins;
		next_q.sync2 = q.sync1;
		next_q.scl_d = scl_h;
		next_q.sda_d = sda_h;
		next_q.push  = 1'h0;
		if (scl_h) begin
			next_q.tcnt = '0;
		end else if (q.tcnt != TW'(P_TIMEOUT_CYC)) begin
			next_q.tcnt = q.tcnt + 1'b1;
		end
		if (q.st == S_WCYC) begin
			// Drain buffered bytes, ignore the bus.
			if (rd_bus.valid) begin
				next_q.mem[rd_bus.data[FIFO_W-1:8]] = rd_bus.data[7:0];
			end
			if (q.wcnt != WW'(P_WRITE_CYC)) begin
				next_q.wcnt = q.wcnt + 1'b1;
			end else if (!rd_bus.valid) begin
				next_q.st = S_IDLE;
			end
		end else if (to_w) begin
			next_q.st        = S_IDLE;
			next_q.drive_low = 1'h0;
			next_q.in_ack    = 1'h0;
			next_q.pend      = 1'h0;
		end else if (start_w) begin
			next_q.st        = S_DEV;
			next_q.bitcnt    = '0;
			next_q.in_ack    = 1'h0;
			next_q.drive_low = 1'h0;
			next_q.nbytes    = '0;
			next_q.pend      = 1'h0;
		end else if (stop_w) begin
			next_q.drive_low = 1'h0;
			next_q.in_ack    = 1'h0;
			next_q.st        = S_IDLE;
			next_q.pend      = 1'h0;
			next_q.wcnt      = '0;
			if (q.st == S_WDATA && q.nbytes != '0) begin
				next_q.st = S_WCYC;
			end else if (q.pend) begin
				unique case (q.cmd)
					CMD_PG0: next_q.page = 1'h0;
					CMD_PG1: next_q.page = 1'h1;
					CMD_CLR: begin
						next_q.wp = '0;
						next_q.st = S_WCYC;
					end
					default: begin
						next_q.wp[spdee_blk(q.cmd)] = 1'h1;
						next_q.st = S_WCYC;
					end
				endcase
			end
		end else if (q.st != S_IDLE && rise_w) begin
			if (q.bitcnt != BYTE_BITS) begin
				next_q.shreg  = {q.shreg[6:0], sda_h};
				next_q.bitcnt = q.bitcnt + 1'b1;
			end else if (q.st == S_RDATA && !q.drive_low) begin
				if (sda_h) begin
					next_q.st = S_IDLE;
				end else if (!q.prot_rd) begin
					next_q.addr  = q.addr + 8'h01;
					next_q.shreg = q.mem[{q.page, q.addr + 8'h01}];
				end
			end
		end else if (q.st != S_IDLE && fall_w) begin
			if (q.in_ack) begin
				next_q.in_ack    = 1'h0;
				next_q.bitcnt    = '0;
				next_q.drive_low = (q.st == S_RDATA) && !q.shreg[7];
			end else if (q.bitcnt != BYTE_BITS) begin
				next_q.drive_low = (q.st == S_RDATA) && !q.shreg[7];
			end else begin
				next_q.in_ack    = 1'h1;
				next_q.drive_low = 1'h0;
				unique case (q.st)
					S_DEV: begin
						next_q.st = S_IDLE;
						if (q.shreg[DS_ID_HI:DS_ID_LO] == P_MEM_TYPE_ID) begin
							if (q.shreg[DS_SEL_HI:DS_SEL_LO] == straps) begin
								next_q.drive_low = 1'h1;
								next_q.prot_rd   = 1'h0;
								next_q.st        = q.shreg[DS_RW] ? S_RDATA : S_WADDR;
								next_q.shreg     = q.mem[{q.page, q.addr}];
							end
						end else if (q.shreg[DS_ID_HI:DS_ID_LO] == P_PROT_TYPE_ID) begin
							next_q.cmd     = q.shreg[DS_SEL_HI:DS_SEL_LO];
							next_q.prot_rd = 1'h1;
							if (!q.shreg[DS_RW]) begin
								if (((spdee_is_blk(q.shreg[DS_SEL_HI:DS_SEL_LO])
									|| q.shreg[DS_SEL_HI:DS_SEL_LO] == CMD_CLR)
									&& q.sync2[PIN_HV])
									|| q.shreg[DS_SEL_HI:DS_SEL_LO] == CMD_PG0
									|| q.shreg[DS_SEL_HI:DS_SEL_LO] == CMD_PG1) begin
									next_q.drive_low = 1'h1;
									next_q.pend      = 1'h1;
									next_q.st        = S_PDUMMY;
								end
							end else if (q.shreg[DS_SEL_HI:DS_SEL_LO] == CMD_PG0) begin
								next_q.drive_low = 1'h1;
								next_q.st        = S_RDATA;
								next_q.shreg     = {7'h00, q.page};
							end else if (spdee_is_blk(q.shreg[DS_SEL_HI:DS_SEL_LO])) begin
								next_q.drive_low = 1'h1;
								next_q.st        = S_RDATA;
								next_q.shreg     = {7'h00,
									q.wp[spdee_blk(q.shreg[DS_SEL_HI:DS_SEL_LO])]};
							end
						end
					end
					S_WADDR: begin
						next_q.addr      = q.shreg;
						next_q.drive_low = 1'h1;
						next_q.st        = S_WDATA;
					end
					S_WDATA: begin
						if (q.nbytes < PAGE_BYTES_MAX && wr_bus.ready
							&& !q.wp[{q.page, q.addr[7]}]) begin
							next_q.push      = 1'h1;
							next_q.push_data = {q.page, q.addr, q.shreg};
							next_q.addr      = {q.addr[7:4], q.addr[3:0] + 4'h1};
							next_q.nbytes    = q.nbytes + 1'b1;
							next_q.drive_low = 1'h1;
						end
					end
					S_PDUMMY: next_q.drive_low = 1'h1;
					default:  next_q.drive_low = 1'h0;
				endcase
			end
		end
	end

	// Array of two pages, delivered erased and unprotected.
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q     <= '0;
			q.mem <= {MEM_WORDS{ERASED}};
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	a_wcyc_no_ack: assert property (
		q.st == S_WCYC |-> !o_sda_oe) else $error("Acknowledge during write cycle.");
	a_drive_on_fall: assert property (
		$rose(o_sda_oe) |-> $past(fall_w)) else $error("Data pulled low off a clock fall.");
	a_strap_mismatch: assert property (
		dec_w && q.st == S_DEV && q.shreg[DS_ID_HI:DS_ID_LO] == P_MEM_TYPE_ID
		&& q.shreg[DS_SEL_HI:DS_SEL_LO] != straps |=> !o_sda_oe ##1 q.st == S_IDLE)
		else $error("Acknowledge without strap match.");
	a_hv_qualify: assert property (
		dec_w && q.st == S_DEV && q.shreg[DS_ID_HI:DS_ID_LO] == P_PROT_TYPE_ID
		&& !q.shreg[DS_RW] && q.shreg[DS_SEL_HI:DS_SEL_LO] == CMD_CLR && !q.sync2[PIN_HV]
		|=> !o_sda_oe) else $error("Protection command taken without high voltage.");
	a_addr_ack: assert property (
		dec_w && q.st == S_WADDR |=> o_sda_oe && q.in_ack)
		else $error("Word address not acknowledged.");
	a_ack_held: assert property (
		q.in_ack && o_sda_oe && !fall_w && !to_w && !stop_w && !start_w |=> o_sda_oe)
		else $error("Acknowledge released early.");
	a_page_limit: assert property (
		q.nbytes <= PAGE_BYTES_MAX) else $error("Page write past sixteen bytes.");
	a_timeout_idle: assert property (
		to_w |=> q.st == S_IDLE && !o_sda_oe) else $error("Timeout did not reach standby.");
	a_timeout_gate: assert property (
		$past(q.st) != S_IDLE && q.st == S_IDLE && $past(q.st) != S_WCYC && $past(q.st) != S_DEV
		&& $past(q.st) != S_RDATA |-> $past(stop_w) || $past(to_w))
		else $error("Interface left its transfer without stop or timeout.");
	a_protect_block: assert property (
		dec_w && q.st == S_WDATA && q.wp[{q.page, q.addr[7]}] |=> !o_sda_oe && !q.push)
		else $error("Write accepted into protected block.");
endmodule

// *** tb/spdee_bus_master.sv ***
/*
 * Behavioural two-wire bus master that drives the serial clock and data.
 * Assumes a pull-up on the data line; the bench resolves the wire level.
 */
`timescale 1ns/1ns
module spdee_bus_master (
	// Bus lines.
	output logic      o_scl,
	output logic      o_sda_low,
	input  wire logic i_sda
);
	localparam int Q = 100;

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start opens frames.
	task automatic start();
		o_sda_low = 1'b0;
		#(Q);
		o_scl = 1'b1;
		#(2*Q);
		o_sda_low = 1'b1;
		#(2*Q);
		o_scl = 1'b0;
		#(Q);
	endtask

	// One clock period; the clock rests low at the end.
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = ~b;
		#(Q);
		o_scl = 1'b1;
		#(Q);
		r = i_sda;
		#(Q);
		o_scl = 1'b0;
		#(Q);
	endtask

	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask

	task automatic recv(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(~ack, r);
	endtask

	task automatic stop();
		o_sda_low = 1'b1;
		#(Q);
		o_scl = 1'b1;
		#(2*Q);
		o_sda_low = 1'b0;
		#(2*Q);
	endtask
endmodule

// *** tb/spdee_target_tb.sv ***
/*
 * Self-checking bench of the two-wire target.
 * Assumes the bus master model and a pull-up on the data wire.
 */
`timescale 1ns/1ns
module spdee_target_tb;
	import spdee_pkg::*;
	localparam logic [3:0] MEM_ID = 4'h5;
	localparam logic [3:0] PRT_ID = 4'h3;
	localparam int         TO_CYC = 200;
	localparam int         WR_CYC = 300;
	logic       clk, nrst, scl, m_low, s0, s1, s2, hv, ack;
	wire logic  sda_out, sda_oe, busy, sda;
	int         err_total, num_checks;
	logic [7:0] rd, a, d;
	logic [2:0] st;
	logic [2:0] codes [4];

	assign sda = (sda_oe ? sda_out : 1'b1) & ~m_low;

	spdee_bus_master m (.o_scl(scl), .o_sda_low(m_low), .i_sda(sda));

	spdee_target #(.P_TIMEOUT_CYC(TO_CYC), .P_WRITE_CYC(WR_CYC), .P_FIFO_DEPTH(FIFO_DEPTH),
		.P_MEM_TYPE_ID(MEM_ID), .P_PROT_TYPE_ID(PRT_ID)) dut (
		.i_core_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe(sda_oe), .i_strap_pin_zero(s0), .i_strap_pin_one(s1),
		.i_strap_pin_two(s2), .i_high_voltage_sense_level(hv), .o_write_busy(busy));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [7:0] sel(input logic [3:0] id, input logic [2:0] f, input logic rw);
		return {id, f, rw};
	endfunction

	task automatic cmd(input logic [7:0] s, input logic exp_ack);
		@(posedge clk);
		#2;
		m.start();
		m.send(s, ack);
		check("select ack", {7'h0, ack}, {7'h0, exp_ack});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (6) @(posedge clk);
		while (busy !== 1'b0 && n < WR_CYC + 200) begin
			@(posedge clk);
			n++;
		end
		#2;
		check("busy end", {7'h0, busy}, 8'h00);
	endtask

	task automatic wait_busy();
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge clk);
			#2;
			n++;
		end
		check("busy start", {7'h0, busy}, 8'h01);
		cmd(sel(MEM_ID, st, 1'b0), 1'b0);
		m.stop();
		wait_idle();
	endtask

	task automatic write_mem(input logic [7:0] addr, input logic [7:0] first, input int n);
		cmd(sel(MEM_ID, st, 1'b0), 1'b1);
		m.send(addr, ack);
		check("address ack", {7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++) begin
			m.send(first + 8'(i), ack);
			check("data ack", {7'h0, ack}, {7'h0, i < 16});
		end
		m.stop();
		wait_busy();
	endtask

	task automatic read_mem(input logic [7:0] addr, input int n, input logic [7:0] first);
		cmd(sel(MEM_ID, st, 1'b0), 1'b1);
		m.send(addr, ack);
		cmd(sel(MEM_ID, st, 1'b1), 1'b1);
		for (int i = 0; i < n; i++) begin
			m.recv(i < n - 1, rd);
			check("read data", rd, first + 8'(i));
		end
		m.stop();
	endtask

	task automatic prot(input logic [2:0] code, input logic rw, input logic exp_ack);
		cmd(sel(PRT_ID, code, rw), exp_ack);
		if (rw) begin
			m.recv(1'b0, rd);
		end else if (exp_ack) begin
			m.send(8'h00, ack);
			m.send(8'h00, ack);
		end
		m.stop();
	endtask

	task automatic drive_hv(input logic v);
		@(posedge clk);
		#2;
		hv = v;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Tests.
	initial begin
		void'($urandom(90651));
		{nrst, s0, s1, s2, hv, err_total, num_checks, st} = '0;
		codes = '{CMD_BLK0, CMD_BLK1, CMD_BLK2, CMD_BLK3};
		repeat (12) @(posedge clk);
		#2;
		nrst = 1'b1;
		repeat (10) @(posedge clk);
		#2;
		check("data out", {7'h0, sda_out}, 8'h00);
		check("pull low", {7'h0, sda_oe}, 8'h00);
		read_mem(8'h42, 1, ERASED);
		$display("test erased done");
		repeat (3) begin
			@(posedge clk);
			#2;
			st = 3'($urandom);
			{s2, s1, s0} = st;
			a = {1'b1, 7'($urandom)};
			d = 8'($urandom);
			write_mem(a, d, 1);
			read_mem(a, 1, d);
		end
		cmd(sel(MEM_ID, st ^ 3'h4, 1'b0), 1'b0);
		m.stop();
		cmd(sel(4'hC, st, 1'b0), 1'b0);
		m.stop();
		$display("test select done");
		write_mem(8'h20, 8'h30, 17);
		read_mem(8'h20, 16, 8'h30);
		$display("test page write done");
		for (int i = 0; i < 4; i++) begin
			drive_hv(1'b0);
			prot(codes[i], 1'b0, 1'b0);
			drive_hv(1'b1);
			prot(codes[i], 1'b0, 1'b1);
			wait_busy();
			prot(codes[i], 1'b1, 1'b1);
			check("protect set", rd, 8'h01);
			if (i == 0) begin
				cmd(sel(MEM_ID, st, 1'b0), 1'b1);
				m.send(8'h10, ack);
				m.send(8'h55, ack);
				check("protected ack", {7'h0, ack}, 8'h00);
				m.stop();
				wait_idle();
				read_mem(8'h10, 1, ERASED);
				drive_hv(1'b0);
				prot(CMD_CLR, 1'b0, 1'b0);
				drive_hv(1'b1);
			end
			prot(CMD_CLR, 1'b0, 1'b1);
			wait_busy();
			prot(codes[i], 1'b1, 1'b1);
			check("protect clear", rd, 8'h00);
		end
		$display("test protect done");
		drive_hv(1'b0);
		prot(CMD_PG1, 1'b0, 1'b1);
		prot(CMD_PG0, 1'b1, 1'b1);
		check("page one", rd, 8'h01);
		read_mem(8'h20, 1, ERASED);
		prot(CMD_PG0, 1'b0, 1'b1);
		prot(CMD_PG0, 1'b1, 1'b1);
		check("page zero", rd, 8'h00);
		$display("test page done");
		@(posedge clk);
		#2;
		m.start();
		d = sel(MEM_ID, st, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			m.bit_io(d[i], ack);
		end
		#((TO_CYC - 30) * 50);
		check("short low", {7'h0, sda_oe}, 8'h01);
		#(60 * 50);
		check("timeout", {7'h0, sda_oe}, 8'h00);
		m.stop();
		cmd(sel(MEM_ID, st, 1'b0), 1'b1);
		m.stop();
		check("data out", {7'h0, sda_out}, 8'h00);
		$display("test timeout done");
		final_report();
	end

	initial begin
		#(3_000_000);
		err_total++;
		$display("watchdog expired");
		final_report();
	end
endmodule
